// >>> verilog/fractional_clock_synth_control.sv
// Clock synthesiser control: APB registers, reference mux, loop core
//
// Operation
// RQ1: Selector code picks one of four references.
// RQ2: Low-rate reference from pin or internal oscillator.
// RQ3: Analogue enable first; digital enable a later write.
// RQ4: Software disables digital before changing settings.
// RQ5: Software resets loop when reference frequency changes.
// RQ6: Output equals reference times N.K times ratio, divided.
// RQ7: Multiplier: ten-bit integer, sixteen-bit half-weighted fraction.
// RQ8: Fraction used only in fractional mode.
// RQ9: Output divider two to thirty-two; reset code 010.
// RQ10: Software keeps oscillator between 90 and 100 MHz.
// RQ11: Loop gain powers of two, x1 to x256.
// RQ12: Control block runs at oscillator over 1..32.
// RQ13: Integer ratio 1 to 31, resets to 14.
// RQ14: Range bit selects high or low reference locking.
// RQ15: Software always uses fractional mode.
// RQ16: Reset multiplier values 086h and C226h.
// RQ17: Disabled loop holds clock low, state cleared.
// RQ18: Settings reach the loop only as one update.
`timescale 1ns/1ns
module fractional_clock_synth_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              master_clock_i,
    input  wire logic              dac_frame_clock_i,
    input  wire logic              adc_frame_clock_i,
    input  wire logic              low_rate_pin_i,
    input  wire logic              low_rate_osc_i,
    output logic                   codec_system_clock_o,
    output logic                   synth_locked_o
);
    import synth_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] enable_divider;
        logic [15:0] ratio_integer;
        logic [15:0] fraction;
        logic [15:0] reference_mode;
        logic        low_rate_from_pin;
        cfg_s        shadow;
        logic        pending;
        logic        ref_prev;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } top_s;

    localparam cfg_s CFG_RST = '0;
    localparam top_s TOP_RST = '{
        enable_divider:    RST_ENABLE_DIVIDER,
        ratio_integer:     RST_RATIO_INTEGER, // [RQ13] [RQ16]
        fraction:          RST_FRACTION,      // [RQ16]
        reference_mode:    RST_REFERENCE_MODE,
        low_rate_from_pin: 1'b0,
        shadow:            CFG_RST,
        pending:           1'b0,
        ref_prev:          1'b0,
        ready:             1'b0,
        slverr:            1'b0,
        rdata:             32'h0000_0000
    };

    top_s        st_ff;
    top_s        nxt_st;
    logic        setup;
    logic        access;
    logic [5:0]  idx;
    logic        aligned;
    logic        mapped;
    logic        cfg_write;
    logic        run;
    logic        nxt_run;
    logic        ref_level;
    logic        ref_edge;
    logic        boundary;
    logic        locked;
    logic [15:0] wdata;
    logic [15:0] rd_word;
    logic [3:0]  status;

    // ------------------------------------------------------------
    // Register image to loop configuration
    // ------------------------------------------------------------
    function automatic cfg_s pack_cfg(input logic [15:0] r1,
                                      input logic [15:0] r2,
                                      input logic [15:0] r3,
                                      input logic [15:0] r4,
                                      input logic        pin);
        cfg_s c;
        c.src_sel      = r4[LSB_SOURCE +: 2];
        c.low_rate_pin = pin;
        c.range        = r4[BIT_RANGE];
        c.frac_mode    = r4[BIT_FRAC_MODE];
        c.ratio        = r2[LSB_RATIO +: 5];
        c.mult_int     = r2[LSB_MULT_INT +: 10];
        c.mult_frac    = r3;
        c.outdiv       = r1[LSB_OUTDIV +: 3];
        c.gain         = r1[LSB_GAIN +: 4];
        c.rate         = r1[LSB_RATE +: 3];
        return c;
    endfunction : pack_cfg

    // ------------------------------------------------------------
    // Reference selection
    // ------------------------------------------------------------
    always_comb begin
        case (st_ff.shadow.src_sel) // [RQ1]
            SRC_MASTER_CLOCK: ref_level = master_clock_i;
            SRC_DAC_FRAME:    ref_level = dac_frame_clock_i;
            SRC_ADC_FRAME:    ref_level = adc_frame_clock_i;
            default: begin
                ref_level = st_ff.shadow.low_rate_pin
                          ? low_rate_pin_i : low_rate_osc_i; // [RQ2]
            end
        endcase
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb begin
        setup   = psel_i && !penable_i;
        access  = psel_i && penable_i && st_ff.ready;
        idx     = paddr_i[7:2];
        aligned = (paddr_i[1:0] == 2'b00)
               && (paddr_i[ADDR_W-1:2] == (ADDR_W-2)'(idx));
        wdata   = pwdata_i[15:0];
        run     = st_ff.enable_divider[BIT_DIGITAL_EN]
               && st_ff.enable_divider[BIT_ANALOG_EN];
        status  = {codec_system_clock_o, st_ff.pending, locked, run};
        mapped  = 1'b0;
        rd_word = 16'h0000;
        if (!aligned) begin
            mapped = 1'b0;
        end else if (idx == IDX_ENABLE_DIVIDER) begin
            mapped  = 1'b1;
            rd_word = st_ff.enable_divider;
        end else if (idx == IDX_RATIO_INTEGER) begin
            mapped  = 1'b1;
            rd_word = st_ff.ratio_integer;
        end else if (idx == IDX_FRACTION) begin
            mapped  = 1'b1;
            rd_word = st_ff.fraction;
        end else if (idx == IDX_REFERENCE_MODE) begin
            mapped  = 1'b1;
            rd_word = st_ff.reference_mode;
        end else if (idx == IDX_LOW_RATE_SOURCE) begin
            mapped  = 1'b1;
            rd_word = {15'h0000, st_ff.low_rate_from_pin};
        end else if (idx == IDX_STATUS) begin
            mapped  = !pwrite_i;
            rd_word = {12'h000, status};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st    = st_ff;
        cfg_write = 1'b0;

        // One setup cycle, then a single access cycle with pready
        nxt_st.ready  = setup;
        nxt_st.slverr = setup && !mapped;
        if (setup) begin
            nxt_st.rdata = (mapped && !pwrite_i)
                         ? {16'h0000, rd_word} : 32'h0000_0000;
        end

        if (access && pwrite_i && !st_ff.slverr) begin
            cfg_write = 1'b1;
            if (idx == IDX_ENABLE_DIVIDER) begin
                nxt_st.enable_divider = wdata & MSK_ENABLE_DIVIDER;
                // Digital enable only sticks once analogue is on
                if (!st_ff.enable_divider[BIT_ANALOG_EN]) begin
                    nxt_st.enable_divider[BIT_DIGITAL_EN] = 1'b0; // [RQ3]
                end
            end else if (idx == IDX_RATIO_INTEGER) begin
                nxt_st.ratio_integer = wdata & MSK_RATIO_INTEGER;
                // Ratio of zero is outside 1..31; keep the old one
                if (wdata[LSB_RATIO +: 5] == 5'h00) begin
                    nxt_st.ratio_integer[LSB_RATIO +: 5] =
                        st_ff.ratio_integer[LSB_RATIO +: 5]; // [RQ13]
                end
            end else if (idx == IDX_FRACTION) begin
                nxt_st.fraction = wdata & MSK_FRACTION;
            end else if (idx == IDX_REFERENCE_MODE) begin
                nxt_st.reference_mode = wdata & MSK_REFERENCE_MODE;
            end else if (idx == IDX_LOW_RATE_SOURCE) begin
                nxt_st.low_rate_from_pin = wdata[0];
            end else begin
                cfg_write = 1'b0;
            end
        end

        nxt_run = nxt_st.enable_divider[BIT_DIGITAL_EN]
               && nxt_st.enable_divider[BIT_ANALOG_EN];

        // While idle the loop follows the registers directly; while
        // running a change waits for the end of an output period so
        // the clock never sees its settings change in the middle of a period.
        // A parked divider shows no clock, so nothing can tear
        if (!run || (st_ff.pending && (boundary
                || st_ff.shadow.outdiv > OUTDIV_MAX))) begin // [RQ18]
            nxt_st.shadow  = pack_cfg(nxt_st.enable_divider,
                                      nxt_st.ratio_integer,
                                      nxt_st.fraction,
                                      nxt_st.reference_mode,
                                      nxt_st.low_rate_from_pin);
            nxt_st.pending = 1'b0;
        end
        // A write in the same cycle as an update still counts
        if (cfg_write && run && nxt_run) begin
            nxt_st.pending = 1'b1; // [RQ18]
        end
        if (!nxt_run) begin
            nxt_st.pending = 1'b0;
        end

        nxt_st.ref_prev = ref_level;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= TOP_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Loop core
    // ------------------------------------------------------------
    assign ref_edge = run && ref_level && !st_ff.ref_prev;

    synth_loop_core #(
        .PHASE_W (24),
        .CNT_W   (15)
    ) u_loop (
        .ref_clk_i  (ref_clk_i),
        .reset_i    (reset_i),
        .run_i      (run), // [RQ17]
        .ref_edge_i (ref_edge),
        .cfg_i      (st_ff.shadow),
        .boundary_o (boundary),
        .locked_o   (locked),
        .clk_o      (codec_system_clock_o)
    );

    assign synth_locked_o = locked;
    assign prdata_o       = st_ff.rdata;
    assign pready_o       = st_ff.ready;
    assign pslverr_o      = st_ff.slverr;

endmodule : fractional_clock_synth_control

// >>> verilog/synth_pkg.sv
// Constants and carrier types for the clock synthesiser control block
package synth_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_ENABLE_DIVIDER  = 6'h2a;
    localparam logic [5:0] IDX_RATIO_INTEGER   = 6'h2b;
    localparam logic [5:0] IDX_FRACTION        = 6'h2c;
    localparam logic [5:0] IDX_REFERENCE_MODE  = 6'h2d;
    localparam logic [5:0] IDX_LOW_RATE_SOURCE = 6'h2e;
    localparam logic [5:0] IDX_STATUS          = 6'h2f;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ENABLE_DIVIDER = 16'h0200;
    localparam logic [15:0] RST_RATIO_INTEGER  = 16'h7086;
    localparam logic [15:0] RST_FRACTION       = 16'hc226;
    localparam logic [15:0] RST_REFERENCE_MODE = 16'h0000;
    localparam logic [15:0] MSK_ENABLE_DIVIDER = 16'hc7f7;
    localparam logic [15:0] MSK_RATIO_INTEGER  = 16'hfbff;
    localparam logic [15:0] MSK_FRACTION       = 16'hffff;
    localparam logic [15:0] MSK_REFERENCE_MODE = 16'h00a3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DIGITAL_EN = 15;
    localparam int BIT_ANALOG_EN  = 14;
    localparam int LSB_OUTDIV     = 8;
    localparam int LSB_GAIN       = 4;
    localparam int LSB_RATE       = 0;
    localparam int LSB_RATIO      = 11;
    localparam int LSB_MULT_INT   = 0;
    localparam int BIT_RANGE      = 7;
    localparam int BIT_FRAC_MODE  = 5;
    localparam int LSB_SOURCE     = 0;

    // ------------------------------------------------------------
    // Field codes and loop constants
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_MASTER_CLOCK = 2'h0;
    localparam logic [1:0] SRC_DAC_FRAME    = 2'h1;
    localparam logic [1:0] SRC_ADC_FRAME    = 2'h2;
    localparam logic [1:0] SRC_LOW_RATE     = 2'h3;
    localparam logic [2:0] OUTDIV_MAX       = 3'h4;
    localparam logic [2:0] RATE_MAX         = 3'h5;
    localparam logic [3:0] GAIN_MAX         = 4'h8;
    localparam int         ERR_SHIFT        = 12;
    localparam int         LOW_RANGE_SHIFT  = 4;
    localparam int         LOCK_TOL         = 32'h0002_0000;
    localparam logic [23:0] FW_INIT         = 24'h400000;
    localparam logic [23:0] FW_MIN          = 24'h000001;

    typedef struct packed {
        logic [1:0]  src_sel;
        logic        low_rate_pin;
        logic        range;
        logic        frac_mode;
        logic [4:0]  ratio;
        logic [9:0]  mult_int;
        logic [15:0] mult_frac;
        logic [2:0]  outdiv;
        logic [3:0]  gain;
        logic [2:0]  rate;
    } cfg_s;

endpackage : synth_pkg

// >>> verilog/synth_loop_core.sv
// Locking loop: oscillator model, loop filter and output divider
`timescale 1ns/1ns
module synth_loop_core #(
    parameter int PHASE_W = 24,
    parameter int CNT_W   = 15
) (
    input  wire logic            ref_clk_i,
    input  wire logic            reset_i,
    input  wire logic            run_i,
    input  wire logic            ref_edge_i,
    input  wire synth_pkg::cfg_s cfg_i,
    output logic                 boundary_o,
    output logic                 locked_o,
    output logic                 clk_o
);
    import synth_pkg::*;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [PHASE_W-1:0] fw;
        logic [CNT_W-1:0]   cnt;
        logic [4:0]         ctrl_div;
        logic [4:0]         out_div;
        logic               clk;
        logic               lock;
    } core_s;

    localparam core_s CORE_RST = '{phase: '0, fw: FW_INIT, cnt: '0,
        ctrl_div: '0, out_div: '0, clk: 1'b0, lock: 1'b0};

    core_s                     st_ff;
    core_s                     nxt_st;
    logic [PHASE_W:0]          sum;
    logic                      osc_tick;
    logic                      ctrl_tick;
    logic [2:0]                rate;
    logic [3:0]                gain;
    logic [4:0]                ctrl_lim;
    logic [4:0]                half_lim;
    logic [15:0]               frac;
    logic [30:0]               target;
    logic signed [31:0]        err;
    logic signed [31:0]        adj;
    logic signed [PHASE_W+1:0] fw_new;

    always_comb begin
        nxt_st   = st_ff;
        sum      = {1'b0, st_ff.phase} + {1'b0, st_ff.fw};
        osc_tick = sum[PHASE_W];
        rate     = (cfg_i.rate > RATE_MAX) ? RATE_MAX : cfg_i.rate; // [RQ12]
        gain     = (cfg_i.gain > GAIN_MAX) ? GAIN_MAX : cfg_i.gain; // [RQ11]
        ctrl_lim = 5'((6'd1 << rate) - 6'd1); // [RQ12]
        ctrl_tick = osc_tick && (st_ff.ctrl_div == ctrl_lim);
        half_lim = 5'((6'd1 << cfg_i.outdiv) - 6'd1); // [RQ9]
        // Integer mode drops the fraction entirely
        frac = cfg_i.frac_mode ? cfg_i.mult_frac : 16'h0000; // [RQ8]
        // Target control-block ticks per reference period, 16 frac bits
        target = 31'({5'h00, cfg_i.mult_int, frac}
                 * {26'h0000000, cfg_i.ratio}) >> rate; // [RQ6] [RQ7]
        err = $signed({1'b0, target})
            - $signed({1'b0, st_ff.cnt, 16'h0000});
        // Low range sees long counts, so the error is damped more
        adj = (err >>> (cfg_i.range ? ERR_SHIFT + LOW_RANGE_SHIFT
                                    : ERR_SHIFT)) <<< gain; // [RQ14]
        fw_new = $signed({2'b00, st_ff.fw}) + adj[PHASE_W+1:0];
        boundary_o = osc_tick && (st_ff.out_div == half_lim) && st_ff.clk;

        nxt_st.phase = sum[PHASE_W-1:0];
        if (osc_tick) begin
            nxt_st.ctrl_div = ctrl_tick ? 5'h00 : st_ff.ctrl_div + 5'h01;
        end
        if (ref_edge_i) begin
            nxt_st.cnt  = '0;
            nxt_st.lock = (err < LOCK_TOL) && (err > -LOCK_TOL);
            if (fw_new <= 0) begin
                nxt_st.fw = FW_MIN;
            end else if (fw_new[PHASE_W+1:PHASE_W] != 2'b00) begin
                nxt_st.fw = '1;
            end else begin
                nxt_st.fw = fw_new[PHASE_W-1:0];
            end
        end else if (ctrl_tick && (st_ff.cnt != '1)) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        // Reserved divider codes park the output low
        if (cfg_i.outdiv > OUTDIV_MAX) begin // [RQ9]
            nxt_st.clk     = 1'b0;
            nxt_st.out_div = 5'h00;
        end else if (osc_tick) begin
            if (st_ff.out_div == half_lim) begin
                nxt_st.out_div = 5'h00;
                nxt_st.clk     = ~st_ff.clk; // [RQ6]
            end else begin
                nxt_st.out_div = st_ff.out_div + 5'h01;
            end
        end
        if (!run_i) begin
            nxt_st = CORE_RST; // [RQ17]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= CORE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign locked_o = st_ff.lock;
    assign clk_o    = st_ff.clk;

endmodule : synth_loop_core

// >>> sim/ref_sources.sv
// Behavioural reference clock sources feeding the synthesiser
`timescale 1ns/1ns
module ref_sources (
    input  wire logic clk_i,
    input  wire logic reset_i,
    output logic      master_clock_o,
    output logic      dac_frame_clock_o,
    output logic      adc_frame_clock_o,
    output logic      low_rate_pin_o,
    output logic      low_rate_osc_o
);
    // --------
    // Sources
    // --------
    logic [9:0] cnt_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i)
            cnt_ff <= 10'h000;
        else
            cnt_ff <= cnt_ff + 10'h001;
    end
    // Distinct rates, so a wrong selection changes the loop's input
    assign master_clock_o    = cnt_ff[1];
    assign dac_frame_clock_o = cnt_ff[5];
    assign adc_frame_clock_o = cnt_ff[6];
    assign low_rate_pin_o    = cnt_ff[8];
    assign low_rate_osc_o    = cnt_ff[9];
endmodule : ref_sources

// >>> sim/synth_checker_sva.sv
// Port-level assertions for the synthesiser control block
`timescale 1ns/1ns
module synth_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              ref_clk_i,
    input wire logic              reset_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              codec_system_clock_o,
    input wire logic              synth_locked_o
);
    // --------
    // Helper state
    // --------
    typedef struct packed {
        logic ana;
        logic off;
    } shadow_s;
    shadow_s st_ff, nxt_st;
    logic        bad;
    logic        commit;
    logic [15:0] rsv;
    always_comb begin
        bad = (paddr_i[1:0] != 2'h0) || (paddr_i < 'ha8) ||
              (paddr_i > 'hbc) || (pwrite_i && paddr_i == 'hbc);
        commit = psel_i && penable_i && pready_o && pwrite_i &&
                 !pslverr_o && paddr_i == 'ha8;
        rsv = (paddr_i == 'ha8) ? 16'h3808 :
              (paddr_i == 'hb4) ? 16'hff5c : 16'h0000;
        nxt_st = st_ff;
        // Digital enable only counts if analogue was already on
        if (commit) begin
            nxt_st.off = !(pwdata_i[15] && st_ff.ana);
            nxt_st.ana = pwdata_i[14];
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i)
            st_ff <= 2'b01;
        else
            st_ff <= nxt_st;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // --------
    // Assertions
    // --------
    a_ready_after_setup: assert property (
        psel_i && !penable_i |=> pready_o)
        else $error("no ready one cycle after setup");
    a_ready_one_cycle: assert property (
        pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (
        pready_o |-> psel_i && penable_i)
        else $error("ready outside an access phase");
    a_error_decode: assert property (
        psel_i && !penable_i |=> pslverr_o == $past(bad))
        else $error("error response does not match address");
    a_error_data_zero: assert property (
        pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("refused access returned data");
    a_reserved_zero: assert property (
        pready_o && !pwrite_i && !pslverr_o |->
        prdata_o[31:16] == 16'h0 && (prdata_o[15:0] & rsv) == 16'h0)
        else $error("reserved read bits not zero");
    a_prdata_hold: assert property (
        pready_o |=> $stable(prdata_o))
        else $error("read data changed after answer");
    a_clock_idle_off: assert property (
        st_ff.off && $past(st_ff.off) && $past(st_ff.off, 2) |->
        !codec_system_clock_o && !synth_locked_o)
        else $error("output active while loop disabled");
endmodule : synth_checker

bind fractional_clock_synth_control synth_checker #(
    .ADDR_W(ADDR_W)
) i_chk (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .codec_system_clock_o(codec_system_clock_o),
    .synth_locked_o(synth_locked_o)
);

// >>> sim/testbench.sv
// Self-checking bench for the synthesiser control block
`timescale 1ns/1ns
module testbench;
    import synth_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        mclk, dclk, aclk, lpin, losc, codec_system_clock, locked, e;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    fractional_clock_synth_control #(.ADDR_W(8)) i_dut (
        .ref_clk_i(clk), .reset_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .master_clock_i(mclk),
        .dac_frame_clock_i(dclk), .adc_frame_clock_i(aclk),
        .low_rate_pin_i(lpin), .low_rate_osc_i(losc),
        .codec_system_clock_o(codec_system_clock), .synth_locked_o(locked));
    ref_sources i_src (
        .clk_i(clk), .reset_i(rst), .master_clock_o(mclk),
        .dac_frame_clock_o(dclk), .adc_frame_clock_o(aclk),
        .low_rate_pin_o(lpin), .low_rate_osc_o(losc));
    // --------
    // Tasks
    // --------
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // No fixed latency assumed: wait for ready under a bound
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d, input logic x);
        apb(a, 1'b1, d);
        chk({31'h0, e}, {31'h0, x});
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] d, input logic x);
        apb(a, 1'b0, 32'h0);
        chk({31'h0, e}, {31'h0, x});
        chk(r, {16'h0, d});
    endtask : rd
    task edges(input int n, output int k);
        logic p;
        k = 0;
        p = codec_system_clock;
        repeat (n) begin
            @(posedge clk);
            if (codec_system_clock === 1'b1 && p === 1'b0)
                k++;
            p = codec_system_clock;
        end
    endtask : edges
    function automatic logic [15:0] mask_of(input logic [7:0] a);
        case (a)
            8'ha8:   return MSK_ENABLE_DIVIDER;
            8'hac:   return MSK_RATIO_INTEGER;
            8'hb0:   return MSK_FRACTION;
            default: return MSK_REFERENCE_MODE;
        endcase
    endfunction : mask_of
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("ERROR %0t: timeout", $time);
            print_verdict();
        end
    end
    // --------
    // Scenarios
    // --------
    initial begin
        logic [7:0]  a;
        logic [31:0] d;
        int          k, kp;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst = 1'b1;
        void'($urandom(24490));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'ha8, 16'h0200, 1'b0);
        rd(8'hac, 16'h7086, 1'b0);
        rd(8'hb0, 16'hc226, 1'b0);
        rd(8'hb4, 16'h0000, 1'b0);
        for (int i = 0; i < 24; i++) begin
            a = 8'ha8 + 8'(4 * (i % 4));
            d = $urandom;
            if (a == 8'ha8)
                d[15:14] = 2'b00;
            if (a == 8'hac && d[15:11] == 5'h0)
                d[11] = 1'b1;
            wr(a, d, 1'b0);
            rd(a, d[15:0] & mask_of(a), 1'b0);
        end
        wr(8'hac, 32'h8123, 1'b0);
        wr(8'hac, 32'h0045, 1'b0);
        rd(8'hac, 16'h8045, 1'b0);
        rd(8'hc0, 16'h0000, 1'b1);
        rd(8'ha9, 16'h0000, 1'b1);
        wr(8'hbc, 32'h1, 1'b1);
        // Unit multiplier: only a four-cycle reference can lock
        wr(8'hac, 32'h0801, 1'b0);
        wr(8'hb0, 32'h0001, 1'b0);
        wr(8'ha8, 32'hc200, 1'b0);
        rd(8'ha8, 16'h4200, 1'b0);
        for (int s = 0; s < 5; s++) begin
            wr(8'ha8, 32'h4200, 1'b0);
            wr(8'hb8, 32'(s == 4), 1'b0);
            wr(8'hb4, 32'h20 | 32'((s > 2) ? 'h83 : s),
               1'b0);
            wr(8'ha8, 32'hc200, 1'b0);
            rd(8'ha8, 16'hc200, 1'b0);
            apb(8'hbc, 1'b0, 32'h0);
            chk({31'h0, r[0]}, 32'h1);
            edges(600, k);
            chk(32'(k > 0), 32'h1);
            apb(8'hbc, 1'b0, 32'h0);
            if (s < 3)
                chk({30'h0, r[1], locked}, {30'h0, {2{s == 0}}});
        end
        rd(8'hb8, 16'h0001, 1'b0);
        // Each larger divider code must give fewer output edges
        kp = 1000000;
        for (int c = 0; c < 5; c++) begin
            wr(8'ha8, 32'h4000 | (32'(c) << 8), 1'b0);
            wr(8'hac, 32'h0808, 1'b0);
            wr(8'hb0, 32'h3127, 1'b0);
            wr(8'ha8, 32'hc000 | (32'(c) << 8), 1'b0);
            edges(1000, k);
            edges(2000, k);
            chk(32'(k < kp && k > 0), 32'h1);
            kp = k;
        end
        wr(8'ha8, 32'h4200, 1'b0);
        // The loop clears one edge after the write lands
        edges(2, k);
        edges(300, k);
        chk(32'(k), 32'h0);
        apb(8'hbc, 1'b0, 32'h0);
        chk(r & 32'h3, 32'h0);
        wr(8'ha8, 32'hc500, 1'b0);
        edges(300, k);
        chk(32'(k), 32'h0);
        print_verdict();
    end
endmodule : testbench
